//--- core/bwis_piso.sv
`timescale 1ns/1ps
`default_nettype none
module bwis_piso #(
  parameter int W = 8
) (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  bwis_sr_if.dev    sr
);
  logic [W-1:0] stage_q;
  logic [W-1:0] stage_d;

  if (W < 2) begin : g_chk
    $error("bwis_piso needs at least two stages");
  end

  // Load wins over shift so a held select keeps stages fresh
  always_comb begin
    stage_d = stage_q;
    if (sr.load) begin
      stage_d = sr.par;
    end else if (sr.shift) begin
      stage_d = {stage_q[W-2:0], sr.ser_in};
    end
  end

  // Stage register
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage_q <= '0;
    end else begin
      stage_q <= stage_d;
    end
  end

  assign sr.ser_out = stage_q[W-1];   // Stage H is the last one

  property p_load;
    @(posedge i_mclk) disable iff (!i_arst_n)
    sr.load |=> stage_q == $past(sr.par);
  endproperty
  a_load: assert property (p_load) else $error("parallel load not taken");

  property p_hold;
    @(posedge i_mclk) disable iff (!i_arst_n)
    (!sr.load && !sr.shift) |=> $stable(stage_q);
  endproperty
  a_hold: assert property (p_hold) else $error("frozen stages changed");

  property p_shift;
    @(posedge i_mclk) disable iff (!i_arst_n)
    (!sr.load && sr.shift) |=> stage_q == {$past(stage_q[W-2:0]), $past(sr.ser_in)};
  endproperty
  a_shift: assert property (p_shift) else $error("shift step wrong");
endmodule
`default_nettype wire

//--- core/bwis_pkg.sv
package bwis_pkg;
  // Channel organisation: two groups of eight
  localparam int CH_PER_GROUP = 8;
  localparam int N_GROUPS     = 2;
  localparam int N_CH         = CH_PER_GROUP * N_GROUPS;

  // Clock rate and timing figures
  localparam int CLK_MHZ      = 200;
  localparam int SW_DELAY_NS  = 1000;   // Optical switch delay, plain default
  localparam int CHARGE_US    = 3000;   // Input capacitor charge time
  localparam int PULSE_US     = 57;     // Receiver pulse after reconnection

  // Least times round up, longest times round down
  localparam int SW_DELAY_CYC = (SW_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int CHARGE_CYC   = CHARGE_US * CLK_MHZ;
  localparam int PULSE_CYC    = PULSE_US * CLK_MHZ;

  // Pin synchroniser depth and reset levels
  localparam int SYNC_STAGES  = 3;
  localparam logic BRK_RST    = 1'b1;   // Control idles high: ground connected
  localparam logic SEL_RST    = 1'b1;   // Host select idles high
  localparam logic SCLK_RST   = 1'b0;
  localparam logic GND_RST    = 1'b1;

  // Ground switch states, Gray coded around the loop
  typedef enum logic [1:0] {
    ST_CONN    = 2'b00,
    ST_OPENING = 2'b01,
    ST_OPEN    = 2'b11,
    ST_CLOSING = 2'b10
  } bwis_gnd_t;
endpackage

//--- core/bwis_sr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface bwis_sr_if #(parameter int W = 8);
  logic         load;
  logic         shift;
  logic         ser_in;
  logic [W-1:0] par;
  logic         ser_out;

  modport dev (input load, input shift, input ser_in, input par, output ser_out);
  modport ctl (output load, output shift, output ser_in, output par, input ser_out);
endinterface
`default_nettype wire

//--- core/bwis_top.sv
//
// Overview of operation
// - Ground stays connected unless control opens it
// - Control low disconnects ground, high connects
// - After reconnection a one means wire intact
// - Broken wire keeps channel output at zero
// - Field high: output follows switch delay
// - Field low: reconnection gives one pulse
// - Two groups of eight feed registers
// - Host select inverted gives shift/load select
// - Select high: registers load channel states
// - Select low: registers freeze their inputs
// - First chains into second; second drives MISO
// - Stream: second group first, then first
// - Shift on each host clock rise with select low; load only select high
//
`timescale 1ns/1ps
`default_nettype none
module bwis_top #(
  parameter int CHARGE_CYC = bwis_pkg::CHARGE_CYC,
  parameter int PULSE_CYC  = bwis_pkg::PULSE_CYC
) (
  input  wire logic                     i_mclk,
  input  wire logic                     i_arst_n,
  input  wire logic                     i_ground_break_line,
  input  wire logic [bwis_pkg::N_CH-1:0] i_wire_intact,
  input  wire logic [bwis_pkg::N_CH-1:0] i_field_level,
  input  wire logic                     i_host_select,
  input  wire logic                     i_host_sclk,
  output logic                          o_host_miso,
  output logic                          o_ground_connected,
  output logic                          o_shift_load_select,
  output logic [bwis_pkg::N_CH-1:0]     o_channel_out
);
  localparam int N  = bwis_pkg::N_CH;
  localparam int CW = bwis_pkg::CH_PER_GROUP;
  localparam int NG = bwis_pkg::N_GROUPS;
  localparam int SW = 2 * N + 3;                   // Synchronised pin count
  localparam int DW = $clog2(bwis_pkg::SW_DELAY_CYC + 1);
  localparam int KW = $clog2(CHARGE_CYC + 1);
  localparam int PW = $clog2(PULSE_CYC + 1);
  localparam logic [DW-1:0] DLY_LAST = DW'(bwis_pkg::SW_DELAY_CYC - 1);
  localparam logic [KW-1:0] CHG_FULL = KW'(CHARGE_CYC);
  localparam logic [PW-1:0] PLS_LEN  = PW'(PULSE_CYC);
  localparam logic [SW-1:0] SYNC_RST = {bwis_pkg::BRK_RST, bwis_pkg::SEL_RST,
                                        bwis_pkg::SCLK_RST, {(2*N){1'b0}}};

  if (CHARGE_CYC < 1 || PULSE_CYC < 1 || NG != 2) begin : g_chk
    $error("bwis_top parameters out of range");
  end

  // Three-stage pin synchroniser with agreement filter
  logic [SW-1:0] s1_q, s2_q, s3_q, agr_q, agr_d;
  logic [SW-1:0] pins;
  assign pins = {i_ground_break_line, i_host_select, i_host_sclk, i_wire_intact, i_field_level};

  // A bit changes only once stages two and three agree
  always_comb begin
    for (int i = 0; i < SW; i++) begin
      agr_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : agr_q[i];
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_q  <= SYNC_RST;
      s2_q  <= SYNC_RST;
      s3_q  <= SYNC_RST;
      agr_q <= SYNC_RST;
    end else begin
      s1_q  <= pins;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      agr_q <= agr_d;
    end
  end

  logic         brk_a, sel_a, sclk_a;
  logic [N-1:0] intact_a, field_a;
  assign brk_a    = agr_q[SW-1];
  assign sel_a    = agr_q[SW-2];
  assign sclk_a   = agr_q[SW-3];
  assign intact_a = agr_q[2*N-1:N];
  assign field_a  = agr_q[N-1:0];

  // Ground switch: each move takes one switch delay
  bwis_pkg::bwis_gnd_t st_q, st_d;
  logic [DW-1:0]       dly_q, dly_d;
  logic                gnd_q, gnd_d, gnd_prev_q;

  always_comb begin
    st_d  = st_q;
    dly_d = '0;
    case (st_q)
      bwis_pkg::ST_CONN: begin
        if (!brk_a) begin
          st_d = bwis_pkg::ST_OPENING;
        end
      end
      bwis_pkg::ST_OPENING: begin
        dly_d = dly_q + DW'(1);
        if (brk_a) begin
          st_d = bwis_pkg::ST_CONN;
        end else if (dly_q == DLY_LAST) begin
          st_d = bwis_pkg::ST_OPEN;
        end
      end
      bwis_pkg::ST_OPEN: begin
        if (brk_a) begin
          st_d = bwis_pkg::ST_CLOSING;
        end
      end
      bwis_pkg::ST_CLOSING: begin
        dly_d = dly_q + DW'(1);
        if (!brk_a) begin
          st_d = bwis_pkg::ST_OPEN;
        end else if (dly_q == DLY_LAST) begin
          st_d = bwis_pkg::ST_CONN;
        end
      end
      default: begin
        st_d = bwis_pkg::ST_CONN;
      end
    endcase
    gnd_d = (st_d == bwis_pkg::ST_CONN) || (st_d == bwis_pkg::ST_OPENING);
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_q       <= bwis_pkg::ST_CONN;
      dly_q      <= '0;
      gnd_q      <= bwis_pkg::GND_RST;
      gnd_prev_q <= bwis_pkg::GND_RST;
    end else begin
      st_q       <= st_d;
      dly_q      <= dly_d;
      gnd_q      <= gnd_d;
      gnd_prev_q <= gnd_q;
    end
  end

  logic reconnect;
  assign reconnect = gnd_q && !gnd_prev_q;

  // Per-channel receiver model: capacitor charge and release pulse
  logic [N-1:0] chan_q;
  for (genvar k = 0; k < N; k++) begin : g_ch
    logic [KW-1:0] cap_q, cap_d;
    logic [PW-1:0] pls_q, pls_d;
    logic          chn_q, chn_d;

    always_comb begin
      cap_d = cap_q;
      pls_d = pls_q;
      if (!gnd_q) begin
        if (intact_a[k] && cap_q != CHG_FULL) begin
          cap_d = cap_q + KW'(1);
        end
        pls_d = '0;
      end else begin
        cap_d = '0;
        if (reconnect && cap_q == CHG_FULL && !field_a[k]) begin
          pls_d = PLS_LEN;
        end else if (pls_q != '0) begin
          pls_d = pls_q - PW'(1);
        end
      end
      chn_d = intact_a[k] && gnd_q && (field_a[k] || pls_q != '0);
    end

    always_ff @(posedge i_mclk or negedge i_arst_n) begin
      if (!i_arst_n) begin
        cap_q     <= '0;
        pls_q     <= '0;
        chn_q     <= 1'b0;
      end else begin
        cap_q     <= cap_d;
        pls_q     <= pls_d;
        chn_q     <= chn_d;
      end
    end

    // One flop per channel, so no vector has two process drivers
    assign chan_q[k] = chn_q;

    property p_broken;
      @(posedge i_mclk) disable iff (!i_arst_n)
      !intact_a[k] |=> !chan_q[k];
    endproperty
    a_broken: assert property (p_broken) else $error("broken wire output high");

    property p_high;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (gnd_q && intact_a[k] && field_a[k]) |=> chan_q[k];
    endproperty
    a_high: assert property (p_high) else $error("high input not passed");

    property p_pulse;
      @(posedge i_mclk) disable iff (!i_arst_n)
      (reconnect && cap_q == CHG_FULL && !field_a[k] && intact_a[k]) |=> ##1 chan_q[k];
    endproperty
    a_pulse: assert property (p_pulse) else $error("missing reconnect pulse");
  end

  // Readout chain: select inverted into shift/load select
  logic sls_q, sclk_prev_q, miso_q;
  logic sclk_rise;
  assign sclk_rise = sclk_a && !sclk_prev_q;

  bwis_sr_if #(.W(CW)) sr_if [NG] ();

  for (genvar g = 0; g < NG; g++) begin : g_sr
    for (genvar b = 0; b < CW; b++) begin : g_bit
      assign sr_if[g].par[CW-1-b] = chan_q[g*CW+b];
    end
    assign sr_if[g].load  = sel_a;
    assign sr_if[g].shift = !sel_a && sclk_rise;
    if (g == 0) begin : g_head
      assign sr_if[g].ser_in = 1'b0;
    end else begin : g_link
      assign sr_if[g].ser_in = sr_if[g-1].ser_out;
    end
    bwis_piso #(.W(CW)) u_sr (
      .i_mclk   (i_mclk),
      .i_arst_n (i_arst_n),
      .sr       (sr_if[g])
    );
  end

  // Output flops; MISO lags the last stage by one cycle
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sls_q       <= !bwis_pkg::SEL_RST;
      sclk_prev_q <= bwis_pkg::SCLK_RST;
      miso_q      <= 1'b0;
    end else begin
      sls_q       <= !sel_a;
      sclk_prev_q <= sclk_a;
      miso_q      <= sr_if[NG-1].ser_out;
    end
  end

  assign o_host_miso         = miso_q;
  assign o_ground_connected  = gnd_q;
  assign o_shift_load_select = sls_q;
  assign o_channel_out       = chan_q;

  property p_inv;
    @(posedge i_mclk) disable iff (!i_arst_n)
    ##1 sls_q == !$past(sel_a);
  endproperty
  a_inv: assert property (p_inv) else $error("select not inverted");

  property p_miso;
    @(posedge i_mclk) disable iff (!i_arst_n)
    ##1 miso_q == $past(sr_if[NG-1].ser_out);
  endproperty
  a_miso: assert property (p_miso) else $error("MISO not from second register");

  property p_open_delay;
    @(posedge i_mclk) disable iff (!i_arst_n)
    $fell(gnd_q) |-> $past(dly_q) == DLY_LAST && !$past(brk_a);
  endproperty
  a_open_delay: assert property (p_open_delay) else $error("opened early");

  property p_stay;
    @(posedge i_mclk) disable iff (!i_arst_n)
    (gnd_q && brk_a) |=> gnd_q;
  endproperty
  a_stay: assert property (p_stay) else $error("ground left without request");
endmodule
`default_nettype wire

//--- sim/bwis_host.sv
`timescale 1ns/1ps
`default_nettype none
module bwis_host (
  input  wire logic i_mclk,
  input  wire logic i_miso,
  output logic      o_select,
  output logic      o_sclk,
  output logic      o_break
);
  // Idle levels: deselected, clock low, ground connected
  initial begin
    o_select = 1'b1;
    o_sclk   = 1'b0;
    o_break  = 1'b1;
  end

  // Every host pin moves only at a falling edge
  task automatic idle(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  // caller holds low long enough to charge
  task automatic brk(input logic lvl, input int hold);
    idle(1);
    o_break = lvl;
    idle(hold);
  endtask

  // Generous settle time covers the pin synchroniser
  task automatic sel(input logic lvl);
    idle(1);
    o_select = lvl;
    idle(10);
  endtask

  // first bit taken before the first rise
  task automatic shift16(output logic [15:0] word);
    for (int k = 0; k < 16; k++) begin
      if (k < 8) begin
        word[8 + k] = i_miso;
      end else begin
        word[k - 8] = i_miso;
      end
      o_sclk = 1'b1;
      idle(6);
      o_sclk = 1'b0;
      idle(6);
    end
  endtask
endmodule
`default_nettype wire

//--- sim/bwis_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module bwis_top_tb_top;
  logic        mclk;
  logic        arst_n;
  logic        brk;
  logic        sel;
  logic        sclk;
  logic        miso;
  logic        gnd;
  logic        sls;
  logic [15:0] intact;
  logic [15:0] field;
  logic [15:0] chout;
  logic [15:0] word;
  int          err_total;
  int          n_checks;
  int          cyc;

  // Switch delay in cycles, and the short pulse used here
  localparam int SW_DLY  = bwis_pkg::SW_DELAY_CYC;
  localparam int PLS_SIM = 10;

  // Short charge and pulse counts keep the run brief
  bwis_top #(.CHARGE_CYC(50), .PULSE_CYC(PLS_SIM)) i_dut (
    .i_mclk              (mclk),
    .i_arst_n            (arst_n),
    .i_ground_break_line (brk),
    .i_wire_intact       (intact),
    .i_field_level       (field),
    .i_host_select       (sel),
    .i_host_sclk         (sclk),
    .o_host_miso         (miso),
    .o_ground_connected  (gnd),
    .o_shift_load_select (sls),
    .o_channel_out       (chout)
  );

  bwis_host i_host (
    .i_mclk   (mclk),
    .i_miso   (miso),
    .o_select (sel),
    .o_sclk   (sclk),
    .o_break  (brk)
  );

  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out;
    $display("Checks made %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait; the switch delay is 200 cycles plus sync
  task automatic wait_gnd(input logic lvl, output int n);
    n = 0;
    while (gnd !== lvl && n < 400) begin
      i_host.idle(1);
      n++;
    end
  endtask

  task automatic t_readout;
    field = 16'ha5c3;
    i_host.idle(8);
    i_host.sel(1'b0);
    chk("shift_load_select", {15'h0, sls}, 16'h0001);
    field = 16'h0f0f;
    i_host.shift16(word);
    chk("frozen word", word, 16'ha5c3);
    i_host.sel(1'b1);
    chk("shift_load_select", {15'h0, sls}, 16'h0000);
    i_host.sel(1'b0);
    i_host.shift16(word);
    chk("reloaded word", word, 16'h0f0f);
    i_host.sel(1'b1);
    $display("Test readout done");
  endtask

  // Pin filter adds about four cycles to each switch delay
  task automatic t_field_high;
    int n;
    field = 16'hffff;
    i_host.brk(1'b0, 1);
    wait_gnd(1'b0, n);
    chk("open delay", {15'h0, n >= SW_DLY && n <= SW_DLY + 6}, 16'h0001);
    i_host.idle(3);
    chk("channel out open", chout, 16'h0000);
    i_host.brk(1'b1, 1);
    wait_gnd(1'b1, n);
    chk("close delay", {15'h0, n >= SW_DLY && n <= SW_DLY + 6}, 16'h0001);
    i_host.idle(3);
    chk("channel out closed", chout, 16'hffff);
    $display("Test field high done");
  endtask

  // Mixed broken and intact wires with field low
  task automatic t_field_low(input logic [15:0] pat);
    int n;
    intact = pat;
    field  = 16'h0000;
    i_host.idle(8);
    i_host.brk(1'b0, 1);
    wait_gnd(1'b0, n);
    i_host.idle(80);
    chk("channel out charging", chout, 16'h0000);
    i_host.brk(1'b1, 1);
    wait_gnd(1'b1, n);
    n = 0;
    while (chout === 16'h0000 && n < 12) begin
      i_host.idle(1);
      n++;
    end
    chk("reconnect pulse", chout, pat);
    i_host.idle(PLS_SIM - 1);
    chk("pulse held", chout, pat);
    i_host.idle(6);
    chk("pulse ended", chout, 16'h0000);
    $display("Test field low done");
  endtask

  // Hang guard, far above the few thousand cycles needed
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      close_out();
    end
  end

  initial begin
    err_total = 0;
    n_checks  = 0;
    cyc       = 0;
    arst_n    = 1'b0;
    intact    = 16'hffff;
    field     = 16'h1234;
    repeat (4) @(posedge mclk);
    chk("ground in reset", {15'h0, gnd}, 16'h0001);
    chk("select in reset", {15'h0, sls}, 16'h0000);
    @(negedge mclk);
    arst_n = 1'b1;
    i_host.idle(10);
    chk("channel out idle", chout, 16'h1234);
    $display("Test reset done");
    t_readout();
    t_field_high();
    t_field_low(16'h3cff);
    t_field_low(16'hc300);
    close_out();
  end
endmodule
`default_nettype wire
